// *** hw/rdmath_pkg.sv ***
package rdmath_pkg;

    // ==========================================================
    // widths and counts
    localparam int INPUTS        = 8;
    localparam int CH_W          = 3;
    localparam int RD_W          = 32;
    localparam int FRAC_BITS     = 16;
    localparam int COEF_W        = 32;
    localparam int DAC_W         = 14;
    localparam int MAN_W         = 16;
    localparam int OUTPUTS       = 2;

    // ==========================================================
    // reading sources
    localparam logic [1:0] SRC_KELVIN  = 2'h0;
    localparam logic [1:0] SRC_CELSIUS = 2'h1;
    localparam logic [1:0] SRC_SENSOR  = 2'h2;
    localparam logic [1:0] SRC_LINEAR  = 2'h3;

    // ==========================================================
    // analog output modes
    localparam logic [1:0] AO_OFF    = 2'h0;
    localparam logic [1:0] AO_MANUAL = 2'h1;
    localparam logic [1:0] AO_INPUT  = 2'h2;

    // ==========================================================
    // filter limits
    localparam logic [6:0] FILT_PTS_MIN = 7'h02;
    localparam logic [6:0] FILT_PTS_MAX = 7'h40;
    localparam logic [3:0] FILT_WIN_MIN = 4'h1;
    localparam logic [3:0] FILT_WIN_MAX = 4'ha;
    localparam int         SETTLE_MULT  = 6;

    // ==========================================================
    // coefficient limits, 16.16 fixed point
    localparam logic [31:0] COEF_MAG_MAX = 32'h270f_e666;
    localparam logic [31:0] COEF_MAG_MIN = 32'h0000_0007;

    // ==========================================================
    // dac codes, offset binary over -10 v .. +10 v, 1.22 mv lsb
    localparam logic [13:0] DAC_ZERO    = 14'h2000;
    localparam logic [13:0] DAC_NEG_FS  = 14'h0000;
    localparam logic [13:0] DAC_POS_FS  = 14'h3fff;
    localparam logic [15:0] MAN_FS      = 16'h2710;

    // ==========================================================
    // register offsets
    localparam logic [7:0] A_CH_SEL    = 8'h00;
    localparam logic [7:0] A_CH_CFG    = 8'h01;
    localparam logic [7:0] A_CH_SLOPE  = 8'h02;
    localparam logic [7:0] A_CH_OFFS   = 8'h03;
    localparam logic [7:0] A_CH_FSR    = 8'h04;
    localparam logic [7:0] A_CH_FILT   = 8'h05;
    localparam logic [7:0] A_CH_LIN    = 8'h06;
    localparam logic [7:0] A_AO0_CFG   = 8'h10;
    localparam logic [7:0] A_AO0_MAN   = 8'h11;
    localparam logic [7:0] A_AO0_LOW   = 8'h12;
    localparam logic [7:0] A_AO0_HIGH  = 8'h13;
    localparam logic [7:0] A_AO0_CODE  = 8'h14;
    localparam logic [7:0] AO_STRIDE   = 8'h08;

    // ==========================================================
    // per-input and per-output configuration field positions and resets
    localparam int CFG_SRC_LSB  = 0;
    localparam int CFG_FEN_BIT  = 2;
    localparam int CFG_PTS_LSB  = 8;
    localparam int CFG_WIN_LSB  = 16;
    localparam int AOC_MODE_LSB = 0;
    localparam int AOC_BIP_BIT  = 2;
    localparam int AOC_MBIP_BIT = 3;
    localparam int AOC_CH_LSB   = 4;
    localparam int AOC_SRC_LSB  = 8;
    localparam logic [31:0] SLOPE_RST = 32'h0001_0000;
    localparam logic [31:0] FSR_RST   = 32'h0001_0000;
    localparam logic [6:0]  PTS_RST   = 7'h08;
    localparam logic [3:0]  WIN_RST   = 4'h1;

endpackage : rdmath_pkg

// *** hw/input_math.sv ***
`timescale 1ns/100ps
`default_nettype none
// one input: selects x, applies slope/offset, smooths with restart window
module input_math (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               rd_valid,
    input  wire logic signed [31:0] rd_kelvin,
    input  wire logic signed [31:0] rd_celsius,
    input  wire logic signed [31:0] rd_sensor,
    input  wire logic [1:0]         src,
    input  wire logic signed [31:0] slope,
    input  wire logic signed [31:0] offs,
    input  wire logic [31:0]        fsr,
    input  wire logic               fen,
    input  wire logic [6:0]         pts,
    input  wire logic [3:0]         win,
    output logic signed [31:0]      k_out,
    output logic signed [31:0]      c_out,
    output logic signed [31:0]      s_out,
    output logic signed [31:0]      lin_out,
    output logic                    restart
);

    typedef struct packed {
        logic signed [31:0] k;
        logic signed [31:0] c;
        logic signed [31:0] s;
        logic signed [31:0] lin;
        logic               rst;
        logic               primed;
    } im_state_t;

    im_state_t st_reg;
    im_state_t st_next;

    // ==========================================================
    // filter step helper
    function automatic logic signed [31:0] smooth(
        input logic signed [31:0] old_v,
        input logic signed [31:0] new_v,
        input logic [6:0]         n
    );
        logic signed [39:0] d;
        d = 40'(new_v) - 40'(old_v);
        smooth = 32'(40'(old_v) + d / $signed({33'h0, n}));
    endfunction : smooth

    logic signed [31:0] x;
    logic signed [63:0] prod;
    logic signed [31:0] lin_raw;
    logic signed [32:0] diff;
    logic [32:0]        mag;
    logic [39:0]        lim;
    logic [6:0]         n_eff;
    logic               jump;

    always_comb begin
        case (src)
            rdmath_pkg::SRC_CELSIUS: x = rd_celsius;
            rdmath_pkg::SRC_SENSOR:  x = rd_sensor;
            default:                 x = rd_kelvin;
        endcase
        prod    = 64'(slope) * 64'(x);
        lin_raw = 32'(prod >>> rdmath_pkg::FRAC_BITS) + offs;
        if (pts < rdmath_pkg::FILT_PTS_MIN)
            n_eff = rdmath_pkg::FILT_PTS_MIN;
        else if (pts > rdmath_pkg::FILT_PTS_MAX)
            n_eff = rdmath_pkg::FILT_PTS_MAX;
        else
            n_eff = pts;
        // window as percent of full scale
        lim  = (40'(fsr) * 40'(win)) / 40'd100;
        // restart on a jump beyond window
        diff = 33'(rd_kelvin) - 33'(st_reg.k);
        mag  = diff[32] ? 33'(-diff) : diff;
        jump = 40'(mag) > lim;
    end

    always_comb begin
        st_next     = st_reg;
        st_next.rst = 1'b0;
        if (rd_valid) begin
            st_next.primed = 1'b1;
            if (!fen || !st_reg.primed) begin
                st_next.k   = rd_kelvin;
                st_next.c   = rd_celsius;
                st_next.s   = rd_sensor;
                st_next.lin = lin_raw;
            end else if (jump) begin
                st_next.rst = 1'b1;
                st_next.k   = rd_kelvin;
                st_next.c   = rd_celsius;
                st_next.s   = rd_sensor;
                st_next.lin = lin_raw;
            end else begin
                st_next.k   = smooth(st_reg.k, rd_kelvin, n_eff);
                st_next.c   = smooth(st_reg.c, rd_celsius, n_eff);
                st_next.s   = smooth(st_reg.s, rd_sensor, n_eff);
                st_next.lin = smooth(st_reg.lin, lin_raw, n_eff);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign k_out   = st_reg.k;
    assign c_out   = st_reg.c;
    assign s_out   = st_reg.s;
    assign lin_out = st_reg.lin;
    assign restart = st_reg.rst;

endmodule : input_math
`default_nettype wire

// *** hw/reading_math_and_analog_out.sv ***
`timescale 1ns/100ps
`default_nettype none
module reading_math_and_analog_out (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               rd_valid,
    input  wire logic [2:0]         rd_ch,
    input  wire logic signed [31:0] rd_kelvin,
    input  wire logic signed [31:0] rd_celsius,
    input  wire logic signed [31:0] rd_sensor,
    input  wire logic [7:0]         addr,
    input  wire logic [31:0]        wdata,
    input  wire logic               wr,
    input  wire logic               rd,
    output logic [31:0]             rdata,
    output logic                    filt_restart,
    output logic [13:0]             dac0_code,
    output logic [13:0]             dac1_code,
    output logic                    dac_update
);

    typedef struct packed {
        logic [1:0]  mode;
        logic        bip;
        logic        man_bip;
        logic [2:0]  ch;
        logic [1:0]  src;
        logic [15:0] man;
        logic [31:0] low;
        logic [31:0] high;
        logic [13:0] code;
    } ao_cfg_t;

    typedef struct packed {
        logic [2:0]                ch_sel;
        logic [7:0][1:0]           src;
        logic [7:0]                fen;
        logic [7:0][6:0]           pts;
        logic [7:0][3:0]           win;
        logic [7:0][31:0]          slope;
        logic [7:0][31:0]          offs;
        logic [7:0][31:0]          fsr;
        logic [1:0]                ao_phase;
        ao_cfg_t [1:0]             ao;
        logic [31:0]               rdata;
        logic                      restart;
        logic                      upd;
    } top_state_t;

    top_state_t st_reg;
    top_state_t st_next;

    logic [7:0][31:0] k_v;
    logic [7:0][31:0] c_v;
    logic [7:0][31:0] s_v;
    logic [7:0][31:0] l_v;
    logic [7:0]       rst_v;

    // ==========================================================
    // per-input math
    genvar gi;
    generate
        for (gi = 0; gi < rdmath_pkg::INPUTS; gi++) begin : g_in
            input_math u_math (
                .clk        (clk),
                .reset      (reset),
                .rd_valid   (rd_valid && rd_ch == 3'(gi)),
                .rd_kelvin  (rd_kelvin),
                .rd_celsius (rd_celsius),
                .rd_sensor  (rd_sensor),
                .src        (st_reg.src[gi]),
                .slope      (st_reg.slope[gi]),
                .offs       (st_reg.offs[gi]),
                .fsr        (st_reg.fsr[gi]),
                .fen        (st_reg.fen[gi]),
                .pts        (st_reg.pts[gi]),
                .win        (st_reg.win[gi]),
                .k_out      (k_v[gi]),
                .c_out      (c_v[gi]),
                .s_out      (s_v[gi]),
                .lin_out    (l_v[gi]),
                .restart    (rst_v[gi])
            );
        end
    endgenerate

    // ==========================================================
    // coefficient magnitude clamp
    function automatic logic [31:0] coef_clamp(input logic [31:0] v);
        logic [31:0] m;
        logic [31:0] r;
        m = v[31] ? 32'(-v) : v;
        if (m > rdmath_pkg::COEF_MAG_MAX)
            m = rdmath_pkg::COEF_MAG_MAX;
        else if (m != 32'h0 && m < rdmath_pkg::COEF_MAG_MIN)
            m = rdmath_pkg::COEF_MAG_MIN;
        r = v[31] ? 32'(-m) : m;
        coef_clamp = r;
    endfunction : coef_clamp

    // ==========================================================
    // output code for one channel
    function automatic logic [13:0] ao_code(
        input ao_cfg_t            c,
        input logic signed [31:0] val
    );
        logic signed [31:0] m;
        logic signed [47:0] num;
        logic signed [47:0] span;
        logic signed [47:0] den;
        logic [13:0]        bot;
        logic [13:0]        res;
        logic signed [31:0] fs;
        m    = 32'sh0;
        fs   = 32'sh0;
        num  = 48'sh0;
        span = 48'sh0;
        den  = 48'sh0;
        bot  = rdmath_pkg::DAC_ZERO;
        res  = rdmath_pkg::DAC_ZERO;
        case (c.mode)
            rdmath_pkg::AO_OFF: res = rdmath_pkg::DAC_ZERO;
            rdmath_pkg::AO_MANUAL: begin
                // percent in 0.01 steps to code
                m  = 32'($signed(c.man));
                // signed copy so both clamps compare signed
                fs = 32'(rdmath_pkg::MAN_FS);
                if (m > fs)
                    m = fs;
                if (m < -fs)
                    m = -fs;
                if (!c.man_bip && m < 0)
                    m = 32'sh0;
                num = 48'(m) * 48'sh2000 / 48'(fs);
                num = num + 48'sh2000;
                if (num > 48'(rdmath_pkg::DAC_POS_FS))
                    num = 48'(rdmath_pkg::DAC_POS_FS);
                res = num[13:0];
            end
            rdmath_pkg::AO_INPUT: begin
                bot  = c.bip ? rdmath_pkg::DAC_NEG_FS
                             : rdmath_pkg::DAC_ZERO;
                span = 48'(rdmath_pkg::DAC_POS_FS) - 48'(bot);
                den  = 48'($signed(c.high)) - 48'($signed(c.low));
                if (val <= $signed(c.low) || den <= 0)
                    res = bot;
                else if (val >= $signed(c.high))
                    res = rdmath_pkg::DAC_POS_FS;
                else begin
                    num = (48'(val) - 48'($signed(c.low))) * span / den;
                    res = 14'(48'(bot) + num);
                end
            end
            default: res = rdmath_pkg::DAC_ZERO;
        endcase
        ao_code = res;
    endfunction : ao_code

    logic [31:0] fval [2];
    logic [7:0]  aoff;
    logic [2:0]  sel;

    // ==========================================================
    // followed value per output
    always_comb begin
        for (int o = 0; o < rdmath_pkg::OUTPUTS; o++) begin
            case (st_reg.ao[o].src)
                rdmath_pkg::SRC_CELSIUS: fval[o] = c_v[st_reg.ao[o].ch];
                rdmath_pkg::SRC_SENSOR:  fval[o] = s_v[st_reg.ao[o].ch];
                rdmath_pkg::SRC_LINEAR:  fval[o] = l_v[st_reg.ao[o].ch];
                default:                 fval[o] = k_v[st_reg.ao[o].ch];
            endcase
        end
    end

    // ==========================================================
    // register file and output update
    always_comb begin
        st_next         = st_reg;
        st_next.restart = |rst_v;
        st_next.upd     = 1'b0;
        sel             = st_reg.ch_sel;
        aoff            = addr - rdmath_pkg::A_AO0_CFG;
        if (wr) begin
            case (addr)
                rdmath_pkg::A_CH_SEL: st_next.ch_sel = wdata[2:0];
                rdmath_pkg::A_CH_CFG: begin
                    st_next.src[sel] =
                        wdata[rdmath_pkg::CFG_SRC_LSB +: 2];
                    st_next.fen[sel] = wdata[rdmath_pkg::CFG_FEN_BIT];
                    st_next.pts[sel] =
                        wdata[rdmath_pkg::CFG_PTS_LSB +: 7];
                    st_next.win[sel] =
                        wdata[rdmath_pkg::CFG_WIN_LSB +: 4];
                    if (st_next.win[sel] < rdmath_pkg::FILT_WIN_MIN)
                        st_next.win[sel] = rdmath_pkg::FILT_WIN_MIN;
                    if (st_next.win[sel] > rdmath_pkg::FILT_WIN_MAX)
                        st_next.win[sel] = rdmath_pkg::FILT_WIN_MAX;
                    // linear source not a legal variable
                    if (st_next.src[sel] == rdmath_pkg::SRC_LINEAR)
                        st_next.src[sel] = rdmath_pkg::SRC_KELVIN;
                end
                rdmath_pkg::A_CH_SLOPE:
                    st_next.slope[sel] = coef_clamp(wdata);
                rdmath_pkg::A_CH_OFFS:
                    st_next.offs[sel] = coef_clamp(wdata);
                rdmath_pkg::A_CH_FSR: st_next.fsr[sel] = wdata;
                default: begin
                    for (int o = 0; o < rdmath_pkg::OUTPUTS; o++) begin
                        if (aoff[7:3] == 5'(o)) begin
                            case (aoff[2:0])
                                3'h0: begin
                                    st_next.ao[o].mode =
                                        wdata[rdmath_pkg::AOC_MODE_LSB +: 2];
                                    if (st_next.ao[o].mode == 2'h3)
                                        st_next.ao[o].mode =
                                            rdmath_pkg::AO_OFF;
                                    st_next.ao[o].bip =
                                        wdata[rdmath_pkg::AOC_BIP_BIT];
                                    st_next.ao[o].man_bip =
                                        wdata[rdmath_pkg::AOC_MBIP_BIT];
                                    st_next.ao[o].ch =
                                        wdata[rdmath_pkg::AOC_CH_LSB +: 3];
                                    st_next.ao[o].src =
                                        wdata[rdmath_pkg::AOC_SRC_LSB +: 2];
                                end
                                3'h1: st_next.ao[o].man  = wdata[15:0];
                                3'h2: st_next.ao[o].low  = wdata;
                                3'h3: st_next.ao[o].high = wdata;
                                default: ;
                            endcase
                        end
                    end
                end
            endcase
        end
        // outputs refresh every fourth cycle, one per cycle
        st_next.ao_phase = st_reg.ao_phase + 2'h1;
        for (int o = 0; o < rdmath_pkg::OUTPUTS; o++) begin
            if (st_reg.ao_phase == 2'(o)) begin
                st_next.ao[o].code = ao_code(st_reg.ao[o], fval[o]);
            end
        end
        st_next.upd = st_reg.ao_phase == 2'h1;
        st_next.rdata = 32'h0;
        if (rd) begin
            case (addr)
                rdmath_pkg::A_CH_SEL: st_next.rdata = 32'(st_reg.ch_sel);
                rdmath_pkg::A_CH_CFG:
                    st_next.rdata = {12'h0, st_reg.win[sel], 1'b0,
                                     st_reg.pts[sel], 5'h0,
                                     st_reg.fen[sel], st_reg.src[sel]};
                rdmath_pkg::A_CH_SLOPE: st_next.rdata = st_reg.slope[sel];
                rdmath_pkg::A_CH_OFFS:  st_next.rdata = st_reg.offs[sel];
                rdmath_pkg::A_CH_FSR:   st_next.rdata = st_reg.fsr[sel];
                rdmath_pkg::A_CH_FILT:  st_next.rdata = k_v[sel];
                rdmath_pkg::A_CH_LIN:   st_next.rdata = l_v[sel];
                default: begin
                    for (int o = 0; o < rdmath_pkg::OUTPUTS; o++) begin
                        if (aoff[7:3] == 5'(o)) begin
                            case (aoff[2:0])
                                3'h0: st_next.rdata = {22'h0,
                                    st_reg.ao[o].src, 1'b0,
                                    st_reg.ao[o].ch, st_reg.ao[o].man_bip,
                                    st_reg.ao[o].bip, st_reg.ao[o].mode};
                                3'h1: st_next.rdata =
                                    {16'h0, st_reg.ao[o].man};
                                3'h2: st_next.rdata = st_reg.ao[o].low;
                                3'h3: st_next.rdata = st_reg.ao[o].high;
                                3'h4: st_next.rdata =
                                    {18'h0, st_reg.ao[o].code};
                                default: ;
                            endcase
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_reg       <= '0;
            for (int i = 0; i < rdmath_pkg::INPUTS; i++) begin
                st_reg.slope[i] <= rdmath_pkg::SLOPE_RST;
                st_reg.fsr[i]   <= rdmath_pkg::FSR_RST;
                st_reg.pts[i]   <= rdmath_pkg::PTS_RST;
                st_reg.win[i]   <= rdmath_pkg::WIN_RST;
            end
            st_reg.ao[0].code <= rdmath_pkg::DAC_ZERO;
            st_reg.ao[1].code <= rdmath_pkg::DAC_ZERO;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata        = st_reg.rdata;
    assign filt_restart = st_reg.restart;
    assign dac0_code    = st_reg.ao[0].code;
    assign dac1_code    = st_reg.ao[1].code;
    assign dac_update   = st_reg.upd;

endmodule : reading_math_and_analog_out
`default_nettype wire

// *** verification/rdmath_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module rdmath_chk (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        rd_valid,
    input wire logic [7:0]  addr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic        filt_restart,
    input wire logic [13:0] dac0_code,
    input wire logic [13:0] dac1_code,
    input wire logic        dac_update
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence quiet3; !dac_update [*3]; endsequence
    sequence upd_hit; dac_update; endsequence
    rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("rdata not zero outside read answer");
    dac_period_a: assert property (
        dac_update |=> quiet3 ##1 upd_hit)
        else $error("dac update spacing wrong");
    reset_code_a: assert property (
        $fell(reset) |-> dac0_code == 14'h2000 && dac1_code == 14'h2000)
        else $error("dac code not zero volts after reset");
    restart_src_a: assert property (
        filt_restart |-> $past(rd_valid, 2))
        else $error("restart without reading");
    unmapped_rd_a: assert property (rd && addr == 8'hff |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    code0_upd_a: assert property (
        $changed(dac0_code) |-> ##[0:4] dac_update)
        else $error("dac0 change without update");
    code1_upd_a: assert property (
        $changed(dac1_code) |-> ##[0:4] dac_update)
        else $error("dac1 change without update");
    code0_rd_a: assert property (rd && addr == 8'h14 |=>
        rdata[13:0] == $past(dac0_code))
        else $error("code0 readback differs");
    code1_rd_a: assert property (rd && addr == 8'h1c |=>
        rdata[13:0] == $past(dac1_code))
        else $error("code1 readback differs");
endmodule : rdmath_chk
bind reading_math_and_analog_out rdmath_chk chk (.clk(clk), .reset(reset),
    .rd_valid(rd_valid), .addr(addr), .rd(rd), .rdata(rdata),
    .filt_restart(filt_restart), .dac0_code(dac0_code),
    .dac1_code(dac1_code), .dac_update(dac_update));
`default_nettype wire

// *** verification/scan_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// sensor scanner: one reading per call, lines scrambled between
module scan_model (
    input  wire logic          clk,
    output logic               rd_valid,
    output logic [2:0]         rd_ch,
    output logic signed [31:0] rd_kelvin,
    output logic signed [31:0] rd_celsius,
    output logic signed [31:0] rd_sensor
);
    initial begin
        {rd_valid, rd_ch, rd_kelvin, rd_celsius, rd_sensor} = '0;
    end
    task automatic send(input logic [2:0] c, input int k, cc, s);
        @(posedge clk);
        rd_valid <= 1'b1;
        {rd_ch, rd_kelvin, rd_celsius, rd_sensor} <= {c, k, cc, s};
        @(posedge clk);
        rd_valid <= 1'b0;
        {rd_ch, rd_kelvin, rd_celsius, rd_sensor} <= ~{c, k, cc, s};
    endtask : send
endmodule : scan_model
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        clk = 0, reset = 1, wr = 0, rd = 0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, r;
    logic        rd_valid, filt_restart, dac_update;
    logic [2:0]  rd_ch;
    logic [31:0] rk, rc, rs;
    logic [13:0] d0, d1;
    int failures = 0, samples_checked = 0, restarts = 0, x, f, p, e;
    int pl[2] = '{2, 64}, mp[4] = '{-10000, 10000, 0, -5000};
    int mb[4] = '{1, 1, 1, 0}, iv[5] = '{5, 5, 10, 200, 200};
    int ib[5] = '{1, 0, 1, 1, 0}, ie[5] = '{0, 8192, 0, 16383, 16383};
    always #12.5 clk = ~clk;
    always @(posedge clk) if (filt_restart === 1'b1) restarts++;
    scan_model scan (.clk(clk), .rd_valid(rd_valid), .rd_ch(rd_ch),
        .rd_kelvin(rk), .rd_celsius(rc), .rd_sensor(rs));
    reading_math_and_analog_out dut (.clk(clk), .reset(reset),
        .rd_valid(rd_valid), .rd_ch(rd_ch), .rd_kelvin(rk),
        .rd_celsius(rc), .rd_sensor(rs), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .filt_restart(filt_restart),
        .dac0_code(d0), .dac1_code(d1), .dac_update(dac_update));
    task automatic check(input string n, input logic [31:0] s, ex);
        samples_checked++;
        if (s !== ex) begin
            failures++;
            $display("unexpected %s exp %h got %h", n, ex, s);
        end
    endtask : check
    task automatic wr_r(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_r
    task automatic rd_r(input logic [7:0] a);
        @(posedge clk);
        {rd, addr} <= {1'b1, a};
        @(posedge clk);
        rd <= 1'b0;
        #1 r = rdata;
    endtask : rd_r
    task automatic wait_dac;
        repeat (8) @(posedge clk);
        #1;
    endtask : wait_dac
    task automatic stop_test;
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test
    initial begin
        #200us;
        failures++;
        stop_test();
    end
    initial begin
        x = $urandom(74356);
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        wait_dac();
        check("dac0", 32'(d0), 32'h2000);
        rd_r(8'hfe);
        wr_r(8'hfe, 32'h5a5a);
        rd_r(8'hff);
        check("unmapped", r, 0);
        wr_r(8'h00, 32'h2);
        wr_r(8'h02, 32'h0002_0000);
        wr_r(8'h03, 32'h0001_0000);
        for (int s = 0; s < 3; s++) begin
            x = $urandom_range(1000, 1);
            wr_r(8'h01, 32'h000a_0200 | s);
            scan.send(3'h2, x <<< 16, (x + 5) <<< 16, (x + 10) <<< 16);
            rd_r(8'h06);
            check("linear", r, (2 * (x + 5 * s) + 1) <<< 16);
        end
        f = x <<< 16;
        wr_r(8'h04, 32'h03e8_0000);
        foreach (pl[i]) begin
            wr_r(8'h01, 32'h000a_0004 | (pl[i] << 8));
            repeat (3) begin
                x += 20;
                scan.send(3'h2, x <<< 16, 0, 0);
                f += ((x <<< 16) - f) / pl[i];
                rd_r(8'h05);
                check("filtered", r, f);
            end
        end
        wr_r(8'h04, 32'h0064_0000);
        wr_r(8'h01, 32'h0001_0204);
        p = restarts;
        x += 50;
        scan.send(3'h2, x <<< 16, 0, 0);
        rd_r(8'h05);
        check("restart", r, x <<< 16);
        repeat (2) @(posedge clk);
        check("restarts", restarts - p, 1);
        foreach (mp[i]) begin
            if (i == 2) mp[i] = $urandom_range(20000) - 10000;
            e = (mb[i] == 0 && mp[i] < 0) ? 0 : mp[i];
            e = 8192 + e * 8192 / 10000;
            if (e > 16383) e = 16383;
            wr_r(8'h10, 32'h1 | (mb[i] << 3));
            wr_r(8'h11, 32'(mp[i]));
            wait_dac();
            rd_r(8'h14);
            check("code0", r, e);
            check("dac1", 32'(d1), 32'h2000);
        end
        wr_r(8'h10, 32'h3);
        wait_dac();
        check("mode3", 32'(d0), 32'h2000);
        wr_r(8'h01, 32'h0000_0200);
        wr_r(8'h1a, 32'h000a_0000);
        wr_r(8'h1b, 32'h0064_0000);
        foreach (iv[i]) begin
            wr_r(8'h18, 32'h22 | (ib[i] << 2));
            scan.send(3'h2, iv[i] <<< 16, 0, 0);
            wait_dac();
            rd_r(8'h1c);
            check("dac1", 32'(d1), ie[i]);
            check("code1", r, ie[i]);
        end
        wr_r(8'h18, 32'h26);
        scan.send(3'h2, 55 <<< 16, 0, 0);
        wait_dac();
        check("mid", 32'(d1 > 14'h1fd0 && d1 < 14'h2030), 1);
        wr_r(8'h18, 32'h326);
        wait_dac();
        check("linfollow", 32'(d1), 32'h3fff);
        wr_r(8'h02, 32'h7fff_ffff);
        rd_r(8'h02);
        check("slopeclamp", r, 32'h270f_e666);
        stop_test();
    end
endmodule : tb
`default_nettype wire
